// ==== rtl/acpd_pkg.sv ====
// Package with constants and types for the AC presence detector
// Operation
// - Each filter samples its comparator on every rising edge of its sample clock.
// - Filter output changes only after the configured run of agreeing samples.
// - All sample clocks are divided from one 1 MHz base tick.
// - Periods offered: 1us x4 up to 2.1s x5, twelve settings.
// - Periods are power-of-two divisions: 1.024ms, 8.192ms, 65.5ms, 2.097s.
// - An N-sample filter settles between N-1 and N sample periods.
// - Above-threshold flag compares rectified input against 65 percent of held peak.
// - Peak-level-ok asserts at 1.85 V and clears at 1.65 V, with hysteresis.
// - Machine moves only on reset, the two flags and its state timers.
// - Each machine input first passes a 4us three-sample filter.
// - The state machine steps at about 7.8 kHz.
// - AC-good stays low until startup peak-ok passes a 1ms x3 filter.
// - AC-good high while AC is normal, low on AC off or fault.
// - AC-good rises only after the above-threshold phase has been seen.
// - Below phase goes to above phase if flag asserts within 8 ms.
// - Above phase returns to below phase when flag drops.
// - Alternating phases within limits keep AC-good high continuously.
// - After reset the machine enters the initial state; AC-good low there.
// - Initial goes to waiting on peak-ok, else low-peak state after 12 ms.
// - Waiting: after 12 ms above flag enters above phase; 25 ms fault; peak loss low-peak.
// - No above flag within 8 ms in below phase: fault, AC-good low, discharge.
package acpd_pkg;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int BASE_HZ = 1_000_000;
   localparam int BASE_DIV = CLK_HZ / BASE_HZ;
   // Divider exponents of the 1 MHz tick, one per sample period
   localparam int EXP_1US = 0;
   localparam int EXP_4US = 2;
   localparam int EXP_16US = 4;
   localparam int EXP_32US = 5;
   localparam int EXP_128US = 7;
   localparam int EXP_1MS = 10;
   localparam int EXP_8MS = 13;
   localparam int EXP_66MS = 16;
   localparam int EXP_2S = 21;
   // State machine tick: 1 MHz / 128 = 7.8125 kHz
   localparam int EXP_FSM = 7;
   localparam int BASE_CNT_W = 21;
   localparam real FSM_PERIOD_US = 128.0;
   localparam real T_INIT_MS = 12.0;
   localparam real T_WAIT_MIN_MS = 12.0;
   localparam real T_WAIT_MAX_MS = 25.0;
   localparam real T_BELOW_MS = 8.0;
   localparam real T_ABOVE_MS = 10.0;
   // Longest times round down, least times round up
   localparam int TK_INIT = int'($floor(T_INIT_MS * 1000.0 / FSM_PERIOD_US));
   localparam int TK_WAIT_MIN = int'($ceil(T_WAIT_MIN_MS * 1000.0 / FSM_PERIOD_US));
   localparam int TK_WAIT_MAX = int'($floor(T_WAIT_MAX_MS * 1000.0 / FSM_PERIOD_US));
   localparam int TK_BELOW = int'($floor(T_BELOW_MS * 1000.0 / FSM_PERIOD_US));
   localparam int TK_ABOVE = int'($ceil(T_ABOVE_MS * 1000.0 / FSM_PERIOD_US));
   localparam int TMR_W = 8;

   // Filter sample counts
   localparam int N_FSM_IN = 3;
   localparam int N_STARTUP = 3;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RESET,
      ST_INIT,
      ST_WAIT,
      ST_ABOVE,
      ST_BELOW,
      ST_LOW_PEAK,
      ST_FAULT
   } acpd_state_t;

   typedef struct packed {
      logic above_threshold_flag;
      logic peak_level_ok;
      logic startup_peak_ok;
   } acpd_cmp_t;

   typedef struct packed {
      logic ac_good_output;
      logic peak_discharge;
      logic [2:0] state;
   } acpd_out_t;

endpackage

// ==== rtl/acpd_top.sv ====
// AC presence detector: sampling filters and AC-on/off state machine
`timescale 1ns/1ns
module acpd_top
   import acpd_pkg::*;
// Clock cycles per 1 MHz base tick; the 7-bit prescaler caps it at 128
#(
   parameter int PRE_DIV = BASE_DIV
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire acpd_pkg::acpd_cmp_t CMP_IN,
   output acpd_pkg::acpd_out_t AC_OUT
);
   import acpd_pkg::*;

   // -------------------------------------------------------------------------
   // Filter function: one sample step
   // -------------------------------------------------------------------------
   // Returns {out, cnt}; cnt counts agreeing samples of the level opposite out
   function automatic logic [4:0] filt_step(
      input logic samp,
      input logic q,
      input logic [3:0] cnt,
      input logic [3:0] n
   );
      logic [4:0] res;
      res = {q, cnt};
      if (samp == q)
      begin
         res = {q, 4'h0};
      end
      else if (cnt + 4'h1 >= n)
      begin
         res = {samp, 4'h0};
      end
      else
      begin
         res = {q, 4'(cnt + 4'h1)};
      end
      return res;
   endfunction

   // -------------------------------------------------------------------------
   // Filter family
   // -------------------------------------------------------------------------
   // Every offered period-by-count setting; only two feed flags in this block
   // and the rest stay ready for further comparators
   typedef enum logic [3:0] {
      FS_1US_X4,
      FS_4US_X3,
      FS_16US_X3,
      FS_32US_X3,
      FS_128US_X3,
      FS_128US_X5,
      FS_1MS_X3,
      FS_1MS_X5,
      FS_8MS_X6,
      FS_66MS_X8,
      FS_2S_X3,
      FS_2S_X5
   } acpd_filt_t;

   // Sample period of a setting as a power-of-two tap of the base tick
   function automatic logic [4:0] filt_exp(input acpd_filt_t f);
      logic [4:0] e;
      case (f)
         FS_1US_X4: e = 5'(EXP_1US);
         FS_4US_X3: e = 5'(EXP_4US);
         FS_16US_X3: e = 5'(EXP_16US);
         FS_32US_X3: e = 5'(EXP_32US);
         FS_128US_X3: e = 5'(EXP_128US);
         FS_128US_X5: e = 5'(EXP_128US);
         FS_1MS_X3: e = 5'(EXP_1MS);
         FS_1MS_X5: e = 5'(EXP_1MS);
         FS_8MS_X6: e = 5'(EXP_8MS);
         FS_66MS_X8: e = 5'(EXP_66MS);
         FS_2S_X3: e = 5'(EXP_2S);
         FS_2S_X5: e = 5'(EXP_2S);
         default: e = 5'(EXP_2S);
      endcase
      return e;
   endfunction

   // Run of agreeing samples that each setting needs before its output moves
   function automatic logic [3:0] filt_len(input acpd_filt_t f);
      logic [3:0] n;
      case (f)
         FS_1US_X4: n = 4'h4;
         FS_4US_X3: n = 4'(N_FSM_IN);
         FS_16US_X3: n = 4'h3;
         FS_32US_X3: n = 4'h3;
         FS_128US_X3: n = 4'h3;
         FS_128US_X5: n = 4'h5;
         FS_1MS_X3: n = 4'(N_STARTUP);
         FS_1MS_X5: n = 4'h5;
         FS_8MS_X6: n = 4'h6;
         FS_66MS_X8: n = 4'h8;
         FS_2S_X3: n = 4'h3;
         FS_2S_X5: n = 4'h5;
         default: n = 4'h3;
      endcase
      return n;
   endfunction

   // Tick of one tap: the low e bits of the next base count roll over to zero.
   // The widest tap, 2^21 base ticks, is the 2.097 s period.
   function automatic logic tap_tick(
      input logic bt,
      input logic [BASE_CNT_W-1:0] inc,
      input logic [4:0] e
   );
      logic [BASE_CNT_W-1:0] mask;
      mask = BASE_CNT_W'((32'h0000_0001 << e) - 32'h0000_0001);
      return bt && ((inc & mask) == '0);
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      acpd_cmp_t sync1;
      acpd_cmp_t sync2;
      logic [6:0] pre;
      logic [BASE_CNT_W-1:0] base;
      logic above_q;
      logic [3:0] above_cnt;
      logic pkok_q;
      logic [3:0] pkok_cnt;
      logic st_q;
      logic [3:0] st_cnt;
      acpd_state_t state;
      logic [TMR_W-1:0] tmr;
      logic seen_above;
      logic good;
      logic dis;
   } acpd_reg_t;

   acpd_reg_t s_r;
   acpd_reg_t s_nxt;

   logic base_tick;
   logic tick_4us;
   logic tick_1ms;
   logic tick_fsm;
   logic [BASE_CNT_W-1:0] base_inc;

   // -------------------------------------------------------------------------
   // Dividers
   // -------------------------------------------------------------------------
   // Power-of-two taps of one counter give every sample rate
   assign base_tick = (s_r.pre == 7'(PRE_DIV - 1));
   assign base_inc = s_r.base + {{(BASE_CNT_W-1){1'b0}}, 1'b1};
   // A tap ticks where its low bits roll over to zero
   assign tick_4us = tap_tick(base_tick, base_inc, filt_exp(FS_4US_X3));
   assign tick_1ms = tap_tick(base_tick, base_inc, filt_exp(FS_1MS_X3));
   assign tick_fsm = tap_tick(base_tick, base_inc, 5'(EXP_FSM));

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      logic [4:0] fr;
      logic ab;
      logic pk;
      fr = 5'h00;
      ab = s_r.above_q;
      pk = s_r.pkok_q;
      s_nxt = s_r;
      // Two-stage synchroniser for the analog comparator flags
      s_nxt.sync1 = CMP_IN;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.pre = base_tick ? 7'h00 : 7'(s_r.pre + 7'h01);
      if (base_tick)
      begin
         s_nxt.base = base_inc;
      end

      // Machine input filters, 4us x3; comparator flags already hold
      // the 65 percent and 1.85/1.65 V hysteresis decisions
      if (tick_4us)
      begin
         fr = filt_step(s_r.sync2.above_threshold_flag, s_r.above_q, s_r.above_cnt,
                        filt_len(FS_4US_X3));
         s_nxt.above_q = fr[4];
         s_nxt.above_cnt = fr[3:0];
         fr = filt_step(s_r.sync2.peak_level_ok, s_r.pkok_q, s_r.pkok_cnt,
                        filt_len(FS_4US_X3));
         s_nxt.pkok_q = fr[4];
         s_nxt.pkok_cnt = fr[3:0];
      end
      // Startup peak filter, 1ms x3; settles 2..3 periods after a change
      if (tick_1ms)
      begin
         fr = filt_step(s_r.sync2.startup_peak_ok, s_r.st_q, s_r.st_cnt,
                        filt_len(FS_1MS_X3));
         s_nxt.st_q = fr[4];
         s_nxt.st_cnt = fr[3:0];
      end

      // State machine steps only on the slow tick
      if (tick_fsm)
      begin
         if (s_r.tmr != '1)
         begin
            s_nxt.tmr = TMR_W'(s_r.tmr + 1'b1);
         end
         case (s_r.state)
            ST_RESET:
            begin
               s_nxt.state = ST_INIT;
               s_nxt.tmr = '0;
            end
            ST_INIT:
            begin
               if (pk)
               begin
                  s_nxt.state = ST_WAIT;
                  s_nxt.tmr = '0;
               end
               else if (s_r.tmr >= TMR_W'(TK_INIT))
               begin
                  s_nxt.state = ST_LOW_PEAK;
                  s_nxt.tmr = '0;
               end
            end
            ST_WAIT:
            begin
               if (!pk)
               begin
                  s_nxt.state = ST_LOW_PEAK;
                  s_nxt.tmr = '0;
               end
               else if (ab && s_r.tmr >= TMR_W'(TK_WAIT_MIN))
               begin
                  s_nxt.state = ST_ABOVE;
                  s_nxt.tmr = '0;
               end
               else if (s_r.tmr >= TMR_W'(TK_WAIT_MAX))
               begin
                  s_nxt.state = ST_FAULT;
                  s_nxt.tmr = '0;
               end
            end
            ST_ABOVE:
            begin
               // AC off is never judged while above threshold
               if (!ab)
               begin
                  s_nxt.state = ST_BELOW;
                  s_nxt.seen_above = 1'b1;
                  s_nxt.tmr = '0;
               end
               else if (s_r.tmr >= TMR_W'(TK_ABOVE))
               begin
                  s_nxt.seen_above = 1'b1;
               end
            end
            ST_BELOW:
            begin
               if (!pk)
               begin
                  s_nxt.state = ST_LOW_PEAK;
                  s_nxt.tmr = '0;
               end
               else if (ab)
               begin
                  s_nxt.state = ST_ABOVE;
                  s_nxt.tmr = '0;
               end
               else if (s_r.tmr >= TMR_W'(TK_BELOW))
               begin
                  s_nxt.state = ST_FAULT;
                  s_nxt.tmr = '0;
               end
            end
            ST_LOW_PEAK:
            begin
               if (pk)
               begin
                  s_nxt.state = ST_WAIT;
                  s_nxt.tmr = '0;
               end
            end
            ST_FAULT:
            begin
               if (!pk)
               begin
                  s_nxt.state = ST_LOW_PEAK;
                  s_nxt.tmr = '0;
               end
               else if (ab)
               begin
                  s_nxt.state = ST_ABOVE;
                  s_nxt.seen_above = 1'b1;
                  s_nxt.tmr = '0;
               end
            end
            default:
            begin
               s_nxt.state = ST_RESET;
               s_nxt.tmr = '0;
            end
         endcase

         // The initial, waiting and low-peak states forget the above phase, so rising
         // again needs a fresh pass through it; the fault state keeps it
         if (s_nxt.state == ST_INIT || s_nxt.state == ST_WAIT ||
             s_nxt.state == ST_LOW_PEAK)
         begin
            s_nxt.seen_above = 1'b0;
         end
         s_nxt.dis = (s_nxt.state == ST_FAULT);
         // Held across above/below alternation without a gap
         s_nxt.good = s_r.st_q && s_nxt.seen_above &&
                      (s_nxt.state == ST_ABOVE || s_nxt.state == ST_BELOW);
      end
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         s_r <= '0;
         s_r.state <= ST_RESET;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign AC_OUT.ac_good_output = s_r.good;
   assign AC_OUT.peak_discharge = s_r.dis;
   assign AC_OUT.state = s_r.state;

endmodule // acpd_top

// ==== sim/acpd_cmp_model.sv ====
// Comparator model that drives the detector flags with short chatter
`timescale 1ns/1ns
module acpd_cmp_model
   import acpd_pkg::*;
(
   input wire logic clk,
   input wire acpd_pkg::acpd_cmp_t level,
   input wire logic glitch_en,
   output acpd_pkg::acpd_cmp_t cmp
);
   int gap = 0;
   int width = 0;
   initial cmp = 3'b000;
   // ----------------
   // Flags with chatter
   // ----------------
   always @(posedge clk)
   begin
      if (gap == 0)
      begin
         gap = 100 + $urandom_range(1000);
         width = 1 + $urandom_range(3);
      end
      gap = gap - 1;
      width = width > 0 ? width - 1 : 0;
      cmp <= level;
      // Pulses of 3 cycles at most stay under one 4 us sample at the bench's
      // base rate; the startup flag is left clean
      if (glitch_en && width > 0)
      begin
         cmp.above_threshold_flag <= ~level.above_threshold_flag;
         cmp.peak_level_ok <= ~level.peak_level_ok;
      end
   end
endmodule // acpd_cmp_model

// ==== sim/acpd_top_sva.sv ====
// Port assertions for the AC presence detector
`timescale 1ns/1ns
module acpd_top_sva
   import acpd_pkg::*;
#(
   parameter int PRE_DIV = BASE_DIV
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire acpd_pkg::acpd_cmp_t CMP_IN,
   input wire acpd_pkg::acpd_out_t AC_OUT
);
   // One machine tick in clock cycles
   localparam int T = 128 * PRE_DIV;
   logic [2:0] st;
   logic [2:0] prev_r;
   logic [23:0] dwell_r;
   logic [23:0] dwell;
   logic [23:0] lo_r;
   logic [19:0] sup_r;
   assign st = AC_OUT.state;
   // The registered count still holds the last state's run on the first cycle
   assign dwell = (st == prev_r) ? dwell_r : 24'h00_0000;
   // ----------------
   // Run counters
   // ----------------
   always_ff @(posedge CLK)
   begin
      prev_r <= st;
      dwell_r <= (SYS_RST || st != prev_r) ? 24'h00_0000 : dwell_r + 24'h00_0001;
      lo_r <= (SYS_RST || CMP_IN.above_threshold_flag) ? 24'h00_0000 : lo_r + 24'h00_0001;
      // Saturates so a long startup level never wraps under the limit
      sup_r <= (SYS_RST || !CMP_IN.startup_peak_ok) ? 20'h0_0000 : sup_r + {19'h0_0000, ~&sup_r};
   end
   // ----------------
   // Properties
   // ----------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_rise;
      $rose(AC_OUT.ac_good_output);
   endsequence
   sequence s_wait_exit;
      ($past(st) == ST_WAIT) ##0 (st == ST_ABOVE);
   endsequence
   chk_reset_clear: assert property (disable iff (1'b0) SYS_RST |=> AC_OUT == 5'h0)
      else $error("outputs not cleared by reset");
   chk_good_where: assert property (AC_OUT.ac_good_output |-> st inside {ST_ABOVE, ST_BELOW})
      else $error("ac good high outside normal phases");
   chk_disch_fault: assert property (AC_OUT.peak_discharge == (st == ST_FAULT))
      else $error("discharge does not match fault state");
   chk_rise_phase: assert property (s_rise |-> $past(st) inside {ST_ABOVE, ST_BELOW, ST_FAULT})
      else $error("ac good rose before above phase seen");
   chk_start_gate: assert property (s_rise |-> sup_r >= 20'(2000 * PRE_DIV))
      else $error("ac good rose before startup level settled");
   chk_tick_hold: assert property (!$stable(AC_OUT) |=> $stable(AC_OUT) [*8])
      else $error("outputs changed between machine ticks");
   chk_init_limit: assert property (st == ST_INIT |-> dwell < 94 * T)
      else $error("initial state held too long");
   chk_below_limit: assert property (st == ST_BELOW |-> dwell < 63 * T)
      else $error("below phase held too long");
   chk_wait_min: assert property (s_wait_exit |-> $past(dwell) >= 93 * T)
      else $error("waiting state left too early");
   chk_above_exit: assert property (st == ST_ABOVE |-> lo_r < 150 * PRE_DIV)
      else $error("above phase kept after flag dropped");
endmodule // acpd_top_sva
bind acpd_top acpd_top_sva #(.PRE_DIV(PRE_DIV)) u_acpd_top_sva (
   .CLK(CLK),
   .SYS_RST(SYS_RST),
   .CMP_IN(CMP_IN),
   .AC_OUT(AC_OUT)
);

// ==== sim/testbench.sv ====
// Self-checking testbench for the AC presence detector
`timescale 1ns/1ns
module testbench;
   import acpd_pkg::*;
   typedef struct {acpd_cmp_t l; logic [2:0] st; int lo; int hi; logic g; int h;} acpd_step_t;
   // A base tick every cycle keeps the run short; tick counts are unchanged
   localparam int PRE_DIV = 1;
   localparam int T = 128 * PRE_DIV;
   logic CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic glitch_en = 1'b0;
   acpd_cmp_t lvl = 3'b000;
   acpd_cmp_t cmp;
   acpd_out_t out;
   int n_errors = 0;
   int samples_checked = 0;
   // Expected state, ac good and tick window for each level change
   acpd_step_t steps[16] = '{
      '{3'b000, ST_INIT, 0, 12, 1'b0, 0},
      '{3'b000, ST_LOW_PEAK, TK_INIT - 1, TK_INIT + 1, 1'b0, 0},
      '{3'b111, ST_WAIT, 0, 2, 1'b0, 0},
      '{3'b111, ST_ABOVE, TK_WAIT_MIN - 1, TK_WAIT_MIN + 2, 1'b0, 0},
      '{3'b111, ST_ABOVE, TK_ABOVE - 2, TK_ABOVE + 2, 1'b1, 0},
      '{3'b011, ST_BELOW, 0, 2, 1'b1, 20},
      '{3'b111, ST_ABOVE, 0, 2, 1'b1, 20},
      '{3'b011, ST_BELOW, 0, 2, 1'b1, 20},
      '{3'b111, ST_ABOVE, 0, 2, 1'b1, 20},
      '{3'b011, ST_BELOW, 0, 2, 1'b1, 20},
      '{3'b111, ST_ABOVE, 0, 2, 1'b1, 0},
      '{3'b011, ST_FAULT, TK_BELOW - 1, TK_BELOW + 2, 1'b0, 0},
      '{3'b111, ST_ABOVE, 0, 2, 1'b1, 0},
      '{3'b011, ST_BELOW, 0, 2, 1'b1, 0},
      '{3'b001, ST_LOW_PEAK, 0, 2, 1'b0, 0},
      '{3'b011, ST_WAIT, 0, 2, 1'b0, 0}
   };
   acpd_cmp_model u_acpd_cmp_model (.clk(CLK), .level(lvl), .glitch_en(glitch_en), .cmp(cmp));
   acpd_top #(.PRE_DIV(PRE_DIV)) u_acpd_top (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .CMP_IN(cmp),
      .AC_OUT(out)
   );
   initial
   begin
      forever #5 CLK = ~CLK;
   end
   task automatic cmp_out(input acpd_out_t e, input acpd_out_t g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD ac_out exp %h got %h", e, g);
      end
   endtask
   task automatic cmp_tick(input int lo, input int hi, input int t);
      samples_checked++;
      if (t < lo || t > hi)
      begin
         n_errors++;
         $display("BAD ticks exp %0d..%0d got %0d", lo, hi, t);
      end
   endtask
   // Applies levels, waits bounded for the expected outputs, checks timing
   task automatic run(input acpd_step_t s);
      int c;
      acpd_out_t e;
      c = 0;
      e = {s.g, s.st == ST_FAULT, s.st};
      @(posedge CLK);
      lvl <= s.l;
      @(negedge CLK);
      while (out !== e && c < (s.hi + 2) * T)
      begin
         @(negedge CLK);
         c++;
      end
      cmp_out(e, out);
      cmp_tick(s.lo, s.hi, c / T);
      repeat ($urandom_range(s.h) * T) @(posedge CLK);
   endtask
   task automatic results();
      if (n_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      repeat (700 * T) @(posedge CLK);
      n_errors++;
      results();
   end
   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      void'($urandom(32'h8126));
      repeat (11) @(posedge CLK);
      @(negedge CLK);
      cmp_out(5'h0, out);
      @(posedge CLK);
      SYS_RST <= 1'b0;
      glitch_en <= 1'b1;
      foreach (steps[i])
         run(steps[i]);
      @(posedge CLK);
      SYS_RST <= 1'b1;
      repeat (2) @(negedge CLK);
      cmp_out(5'h0, out);
      results();
   end
endmodule // testbench
